// [core/iref_ctrl.sv]
// Interrupt enable and request-flag logic with AXI4-Lite register access
`timescale 1ns/1ps

// Behaviour
// - Second enable bit2 enables third external
// - Second enable bit1 enables timer 3
// - Second enable bit0 enables converter
// - Request bit2 pending third external interrupt
// - Request bit1 set by timer 3 reload
// - Request bit0 pending converter interrupt
// - Timer control bit7 is timer 1 flag
// - Timer control bit5 is timer 0 flag
// - Timer control bit3 second external flag
// - Timer control bit1 first external flag
// - Serial bit1 set on transmit done
// - Serial bit0 set on receive done
// - Fixed vector addresses per source
// - Fetch starts at zero, user at 0x00EC
// - Enable bit7 is global interrupt gate for o_irq_req; o_irq_line ignores it
// - Enabled flags auto-clear on servicing, except the serial pair
module iref_ctrl #(
    parameter logic [15:0] VEC_EXT1   = 16'h0013,
    parameter logic [15:0] VEC_TIMER1 = 16'h001B,
    parameter logic [15:0] VEC_SERIAL = 16'h0023,
    parameter logic [15:0] VEC_TIMER3 = 16'h002B,
    parameter logic [15:0] VEC_CONV   = 16'h0033
) (
    // Clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst,
    // Source events, one-cycle pulses
    input  wire logic                       i_ext0_evt,
    input  wire logic                       i_ext1_evt,
    input  wire logic                       i_ext2_evt,
    input  wire logic                       i_timer0_evt,
    input  wire logic                       i_timer1_evt,
    input  wire logic                       i_timer3_evt,
    input  wire logic                       i_conv_evt,
    input  wire logic                       i_tx_done_evt,
    input  wire logic                       i_rx_done_evt,
    // Core side
    input  wire logic                       i_irq_ack,
    output logic                            o_irq_req,
    output logic [15:0]                     o_irq_vector,
    output logic [15:0]                     o_boot_addr,
    output logic [15:0]                     o_user_start,
    output logic                            o_irq_line,
    // AXI4-Lite write
    input  wire logic [iref_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [31:0]                i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    output logic [1:0]                      o_bresp,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    // AXI4-Lite read
    input  wire logic [iref_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    output logic [31:0]                     o_rdata,
    output logic [1:0]                      o_rresp,
    output logic                            o_rvalid,
    input  wire logic                       i_rready
);

    localparam int NS = iref_pkg::NUM_SRC;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] first_src(input logic [NS-1:0] pend);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = NS - 1; k >= 0; k--)
        begin
            if (pend[k])
            begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction : first_src

    function automatic logic is_reg(input logic [iref_pkg::ADDR_W-1:0] a,
                                    input logic [9:0] idx);
        return (a[iref_pkg::ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction : is_reg

    // ****************************************
    // State
    // ****************************************
    logic [NS-1:0]                 flag_r;
    logic [NS-1:0]                 evt_sts_r;
    logic [NS-1:0]                 evt_en_r;
    logic [iref_pkg::IEN1_W-1:0]   ien1_r;
    logic                          glob_en_r;
    logic [2:0]                    second_irq_enable_r;
    logic [3:0]                    src_r;
    logic                          aw_have_r;
    logic                          w_have_r;
    logic [iref_pkg::ADDR_W-1:0]   aw_addr_r;
    logic [31:0]                   w_data_r;
    logic [3:0]                    w_strb_r;

    // ****************************************
    // Event vector and enables
    // ****************************************
    wire logic [NS-1:0] evt = {i_conv_evt, i_ext2_evt, i_timer3_evt, i_rx_done_evt,
                               i_tx_done_evt, i_timer1_evt, i_ext1_evt, i_timer0_evt,
                               i_ext0_evt};
    wire logic [NS-1:0] src_en = {second_irq_enable_r[iref_pkg::BIT_CONV],
                                  second_irq_enable_r[iref_pkg::BIT_EXT2],
                                  second_irq_enable_r[iref_pkg::BIT_TIMER3],
                                  ien1_r[4], ien1_r[4], ien1_r[3],
                                  ien1_r[2], ien1_r[1], ien1_r[0]};
    wire logic [NS-1:0] pend     = flag_r & src_en & {NS{glob_en_r}};
    wire logic          any_pend = |pend;
    wire logic [3:0]    pick     = first_src(pend);

    wire logic [15:0] vec_tab [NS] = '{iref_pkg::VEC_EXT0, iref_pkg::VEC_TIMER0,
                                       VEC_EXT1, VEC_TIMER1, VEC_SERIAL, VEC_SERIAL,
                                       VEC_TIMER3, iref_pkg::VEC_EXT2, VEC_CONV};

    // ****************************************
    // Write decode
    // ****************************************
    wire logic do_wr  = aw_have_r && w_have_r && !o_bvalid;
    wire logic wr_b0  = do_wr && w_strb_r[0];
    wire logic wr_tcn = wr_b0 && is_reg(aw_addr_r, iref_pkg::IDX_TMR_FLAGS);
    wire logic wr_ser = wr_b0 && is_reg(aw_addr_r, iref_pkg::IDX_SER_FLAGS);
    wire logic wr_ie2 = wr_b0 && is_reg(aw_addr_r, iref_pkg::IDX_EN2);
    wire logic wr_ie1 = wr_b0 && is_reg(aw_addr_r, iref_pkg::IDX_IEN1);
    wire logic wr_rq2 = wr_b0 && is_reg(aw_addr_r, iref_pkg::IDX_IRQ2);
    wire logic wr_clr = do_wr && is_reg(aw_addr_r, iref_pkg::IDX_EVT_CLR);
    wire logic wr_een = do_wr && is_reg(aw_addr_r, iref_pkg::IDX_EVT_EN);
    wire logic wr_map = wr_tcn || wr_ser || wr_ie2 || wr_ie1 || wr_rq2 || wr_clr || wr_een
                        || is_reg(aw_addr_r, iref_pkg::IDX_EVT_STS);
    wire logic [7:0] wd = w_data_r[7:0];

    // Software image of each flag and which flags this write touches
    wire logic [NS-1:0] sw_val = {wd[iref_pkg::BIT_CONV], wd[iref_pkg::BIT_EXT2],
                                  wd[iref_pkg::BIT_TIMER3], wd[iref_pkg::BIT_RX_FLAG],
                                  wd[iref_pkg::BIT_TX_FLAG], wd[iref_pkg::BIT_T1_FLAG],
                                  wd[iref_pkg::BIT_E1_FLAG], wd[iref_pkg::BIT_T0_FLAG],
                                  wd[iref_pkg::BIT_E0_FLAG]};
    wire logic [NS-1:0] sw_sel = {{3{wr_rq2}}, {2{wr_ser}}, {4{wr_tcn}}};

    // Servicing clears the taken flag, except the serial pair
    wire logic          hw_clr_en = i_irq_ack && o_irq_req
                                    && (src_r != 4'(iref_pkg::SRC_TX))
                                    && (src_r != 4'(iref_pkg::SRC_RX));
    wire logic [NS-1:0] hw_clr    = hw_clr_en ? (NS'(1) << src_r) : '0;

    // Set wins over any clear in the same cycle
    wire logic [NS-1:0] flag_nxt = evt | (sw_sel & sw_val)
                                   | (flag_r & ~sw_sel & ~hw_clr);
    wire logic [NS-1:0] sts_nxt  = evt | (evt_sts_r & ~(wr_clr ? w_data_r[NS-1:0] : '0));
    // Line follows a new enable at once, not one cycle late
    wire logic [NS-1:0] en_nxt   = wr_een ? w_data_r[NS-1:0] : evt_en_r;

    // ****************************************
    // Read mux
    // ****************************************
    wire logic [7:0] rd_tcn = {flag_r[iref_pkg::SRC_TIMER1], 1'b0, flag_r[iref_pkg::SRC_TIMER0],
                               1'b0, flag_r[iref_pkg::SRC_EXT1], 1'b0,
                               flag_r[iref_pkg::SRC_EXT0], 1'b0};
    wire logic [7:0] rd_ser = {6'h00, flag_r[iref_pkg::SRC_TX], flag_r[iref_pkg::SRC_RX]};
    wire logic [7:0] rd_rq2 = {5'h00, flag_r[iref_pkg::SRC_EXT2], flag_r[iref_pkg::SRC_TIMER3],
                               flag_r[iref_pkg::SRC_CONV]};
    wire logic [7:0] rd_ie1 = {glob_en_r, 2'h0, ien1_r};
    wire logic ar_hit = is_reg(i_araddr, iref_pkg::IDX_TMR_FLAGS)
                     || is_reg(i_araddr, iref_pkg::IDX_SER_FLAGS)
                     || is_reg(i_araddr, iref_pkg::IDX_EN2)
                     || is_reg(i_araddr, iref_pkg::IDX_IEN1)
                     || is_reg(i_araddr, iref_pkg::IDX_IRQ2)
                     || is_reg(i_araddr, iref_pkg::IDX_EVT_STS)
                     || is_reg(i_araddr, iref_pkg::IDX_EVT_CLR)
                     || is_reg(i_araddr, iref_pkg::IDX_EVT_EN);
    wire logic [31:0] rd_val =
        is_reg(i_araddr, iref_pkg::IDX_TMR_FLAGS)  ? {24'h000000, rd_tcn} :
        is_reg(i_araddr, iref_pkg::IDX_SER_FLAGS)  ? {24'h000000, rd_ser} :
        is_reg(i_araddr, iref_pkg::IDX_EN2)        ? {29'h00000000, second_irq_enable_r} :
        is_reg(i_araddr, iref_pkg::IDX_IEN1)       ? {24'h000000, rd_ie1} :
        is_reg(i_araddr, iref_pkg::IDX_IRQ2)       ? {24'h000000, rd_rq2} :
        is_reg(i_araddr, iref_pkg::IDX_EVT_STS)    ? {23'h000000, evt_sts_r} :
        is_reg(i_araddr, iref_pkg::IDX_EVT_EN)     ? {23'h000000, evt_en_r} : 32'h00000000;

    // ****************************************
    // Flags, enables and core request
    // ****************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            flag_r       <= '0;
            evt_sts_r    <= '0;
            evt_en_r     <= '0;
            ien1_r       <= '0;
            glob_en_r    <= 1'b0;
            second_irq_enable_r       <= 3'h0;
            src_r        <= 4'h0;
            o_irq_req    <= 1'b0;
            o_irq_vector <= iref_pkg::BOOT_ADDR;
            o_irq_line   <= 1'b0;
            o_boot_addr  <= iref_pkg::BOOT_ADDR;
            o_user_start <= iref_pkg::USER_START;
        end
        else
        begin
            flag_r       <= flag_nxt;
            evt_sts_r    <= sts_nxt;
            src_r        <= pick;
            o_irq_vector <= vec_tab[pick];
            // A serviced source other than the serial pair drops its request at once; no stale re-request
            o_irq_req    <= any_pend && !hw_clr_en;
            o_irq_line   <= |(sts_nxt & en_nxt);
            if (wr_een)
            begin
                evt_en_r <= w_data_r[NS-1:0];
            end
            if (wr_ie1)
            begin
                glob_en_r <= wd[iref_pkg::BIT_GLOBAL];
                ien1_r    <= wd[iref_pkg::IEN1_W-1:0];
            end
            if (wr_ie2)
            begin
                second_irq_enable_r <= wd[2:0];
            end
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            o_awready <= 1'b0;
            o_wready  <= 1'b0;
            o_bvalid  <= 1'b0;
            o_bresp   <= iref_pkg::RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= iref_pkg::RESP_OKAY;
        end
        else
        begin
            o_awready <= !aw_have_r && !(i_awvalid && o_awready);
            o_wready  <= !w_have_r && !(i_wvalid && o_wready);
            if (i_awvalid && o_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= i_awaddr;
            end
            if (i_wvalid && o_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= i_wdata;
                w_strb_r <= i_wstrb;
            end
            if (do_wr)
            begin
                o_bvalid <= 1'b1;
                o_bresp  <= wr_map ? iref_pkg::RESP_OKAY : iref_pkg::RESP_DECERR;
            end
            else if (o_bvalid && i_bready)
            begin
                o_bvalid  <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                o_awready <= 1'b0;
                o_wready  <= 1'b0;
            end
            // Reads take one cycle and have no side effects
            o_arready <= !o_rvalid && !(i_arvalid && o_arready);
            if (i_arvalid && o_arready)
            begin
                o_rvalid <= 1'b1;
                o_rdata  <= rd_val;
                o_rresp  <= ar_hit ? iref_pkg::RESP_OKAY : iref_pkg::RESP_DECERR;
            end
            else if (o_rvalid && i_rready)
            begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_ext2_enable_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!second_irq_enable_r[iref_pkg::BIT_EXT2] && !wr_ie2) |=> !pend[iref_pkg::SRC_EXT2])
        else $error("third external request passed while disabled");

    a_timer3_enable_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (flag_r[iref_pkg::SRC_TIMER3] && second_irq_enable_r[iref_pkg::BIT_TIMER3] && glob_en_r)
        |-> pend[iref_pkg::SRC_TIMER3])
        else $error("timer 3 request not pending when enabled");

    a_conv_enable_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        pend[iref_pkg::SRC_CONV] |-> second_irq_enable_r[iref_pkg::BIT_CONV])
        else $error("converter request without its enable");

    a_ext2_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_ext2_evt |=> rd_rq2[iref_pkg::BIT_EXT2])
        else $error("third external flag not set by event");

    a_timer3_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_timer3_evt |=> rd_rq2[iref_pkg::BIT_TIMER3])
        else $error("timer 3 flag not set by event");

    a_conv_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_conv_evt |=> rd_rq2[iref_pkg::BIT_CONV])
        else $error("converter flag not set by event");

    a_timer_flags_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_timer1_evt && i_timer0_evt) |=> (rd_tcn[iref_pkg::BIT_T1_FLAG]
                                          && rd_tcn[iref_pkg::BIT_T0_FLAG]))
        else $error("timer 0 or 1 flag not set by event");

    a_ext_flags_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_ext1_evt ##1 i_ext0_evt |=> (rd_tcn[iref_pkg::BIT_E1_FLAG]
                                      || $past(hw_clr_en) || $past(wr_tcn))
                                      && rd_tcn[iref_pkg::BIT_E0_FLAG])
        else $error("external flag not set by event");

    a_serial_flags_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_tx_done_evt || i_rx_done_evt) |=> (rd_ser != 8'h00))
        else $error("serial flag not set by event");

    a_serial_no_autoclr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (flag_r[iref_pkg::SRC_TX] && !wr_ser) |=> flag_r[iref_pkg::SRC_TX])
        else $error("serial transmit flag cleared without software");

    a_vector_ext0: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_irq_req && src_r == 4'(iref_pkg::SRC_EXT0)) |-> (o_irq_vector == iref_pkg::VEC_EXT0))
        else $error("wrong vector for first external source");

    a_boot_fixed: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $past(i_rst) |-> (o_boot_addr == iref_pkg::BOOT_ADDR)
                         && (o_user_start == iref_pkg::USER_START))
        else $error("boot addresses wrong after reset");

    a_global_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!glob_en_r && !wr_ie1) [*2] |-> !o_irq_req)
        else $error("request raised while globally disabled");

    a_ack_clears: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (hw_clr_en && src_r == 4'(iref_pkg::SRC_TIMER0) && !i_timer0_evt && !wr_tcn)
        |=> !flag_r[iref_pkg::SRC_TIMER0])
        else $error("serviced timer 0 flag not cleared");

    a_req_needs_all: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_irq_req |-> $past(any_pend))
        else $error("request without an enabled pending flag");

    a_line_level: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_irq_line == (|(evt_sts_r & evt_en_r)))
        else $error("interrupt line does not follow enabled status");

endmodule : iref_ctrl

// [core/iref_pkg.sv]
// Constants for the interrupt enable and request-flag block
package iref_pkg;

    // ****************************************
    // Register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [9:0] IDX_TMR_FLAGS  = 10'h088;
    localparam logic [9:0] IDX_SER_FLAGS  = 10'h098;
    localparam logic [9:0] IDX_EN2        = 10'h09A;
    localparam logic [9:0] IDX_IEN1       = 10'h0A8;
    localparam logic [9:0] IDX_IRQ2       = 10'h0BF;
    localparam logic [9:0] IDX_EVT_STS    = 10'h0C0;
    localparam logic [9:0] IDX_EVT_CLR    = 10'h0C1;
    localparam logic [9:0] IDX_EVT_EN     = 10'h0C2;
    localparam int         ADDR_W         = 12;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_T1_FLAG  = 7;
    localparam int BIT_T0_FLAG  = 5;
    localparam int BIT_E1_FLAG  = 3;
    localparam int BIT_E0_FLAG  = 1;
    localparam int BIT_TX_FLAG  = 1;
    localparam int BIT_RX_FLAG  = 0;
    localparam int BIT_EXT2     = 2;
    localparam int BIT_TIMER3   = 1;
    localparam int BIT_CONV     = 0;
    localparam int BIT_GLOBAL   = 7;
    localparam int IEN1_W       = 5;

    // ****************************************
    // Source indices, in natural priority order
    // ****************************************
    localparam int SRC_EXT0   = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1   = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_TX     = 4;
    localparam int SRC_RX     = 5;
    localparam int SRC_TIMER3 = 6;
    localparam int SRC_EXT2   = 7;
    localparam int SRC_CONV   = 8;
    localparam int NUM_SRC    = 9;

    // ****************************************
    // Reset values and fixed addresses
    // ****************************************
    localparam logic [7:0]  RST_REG8    = 8'h00;
    localparam logic [15:0] VEC_EXT0    = 16'h0003;
    localparam logic [15:0] VEC_TIMER0  = 16'h000B;
    localparam logic [15:0] VEC_EXT2    = 16'h0083;
    localparam logic [15:0] BOOT_ADDR   = 16'h0000;
    localparam logic [15:0] USER_START  = 16'h00EC;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_DECERR = 2'h3;

endpackage : iref_pkg

// [tb/iref_core_model.sv]
// Behavioural model of the core that takes vectored requests
`timescale 1ns/1ps
module iref_core_model (
    // Clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    // Bench control: permission to enter, delay before entry
    input  wire logic        i_take,
    input  wire logic [3:0]  i_gap,
    // Request side
    input  wire logic        i_irq_req,
    input  wire logic [15:0] i_irq_vector,
    output logic             o_irq_ack,
    output logic [15:0]      o_vec_r,
    output logic [7:0]       o_cnt_r
);
    logic [3:0] wait_r;
    // Acks are single pulses, never back to back, so a taken request has time to fall
    always_ff @(posedge i_sys_clk)
    begin
        o_irq_ack <= 1'b0;
        if (i_rst)
        begin
            wait_r  <= 4'h0;
            o_cnt_r <= 8'h00;
        end
        else if (!i_irq_req)
            wait_r <= i_gap;
        else if (wait_r != 4'h0)
            wait_r <= wait_r - 4'h1;
        else if (i_take && !o_irq_ack)
        begin
            o_irq_ack <= 1'b1;
            o_vec_r   <= i_irq_vector;
            o_cnt_r   <= o_cnt_r + 8'h01;
        end
    end
endmodule : iref_core_model

// [tb/tb.sv]
// Self-checking bench for the interrupt enable and request-flag block
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0, rst = 1'b1, take = 1'b0;
    logic [8:0]  evt = 9'h000;
    logic [3:0]  gap = 4'h0;
    logic        ack, req, line, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] vec, boot, ustart, cvec;
    logic [7:0]  ccnt, c;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, d, seed = 32'h9EEF;
    logic [1:0]  bresp, rresp, r;
    int          miscompares = 0, n_tests = 0;
    // Sources in priority order: ext a, timer0, ext b, timer1, tx, rx, timer3, ext c, conv
    localparam logic [15:0] VECS [0:8] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
                                           16'h0023, 16'h002B, 16'h0083, 16'h0033};
    localparam logic [3:0]  POS [0:8]  = '{4'h1, 4'h5, 4'h3, 4'h7, 4'h1, 4'h0, 4'h1, 4'h2, 4'h0};
    localparam logic [11:0] RST_A [0:4] = '{12'h220, 12'h260, 12'h268, 12'h2FC, 12'h300};
    always #25 clk = ~clk;
    iref_ctrl DUT (.i_sys_clk(clk), .i_rst(rst), .i_ext0_evt(evt[0]), .i_timer0_evt(evt[1]),
        .i_ext1_evt(evt[2]), .i_timer1_evt(evt[3]), .i_tx_done_evt(evt[4]),
        .i_rx_done_evt(evt[5]), .i_timer3_evt(evt[6]), .i_ext2_evt(evt[7]), .i_conv_evt(evt[8]),
        .i_irq_ack(ack), .o_irq_req(req), .o_irq_vector(vec), .o_boot_addr(boot),
        .o_user_start(ustart), .o_irq_line(line), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awrdy), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wrdy),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(arrdy), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready));
    iref_core_model core (.i_sys_clk(clk), .i_rst(rst), .i_take(take), .i_gap(gap),
        .i_irq_req(req), .i_irq_vector(vec), .o_irq_ack(ack), .o_vec_r(cvec), .o_cnt_r(ccnt));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [11:0] flag_addr(input int i);
        return (i < 4) ? 12'h220 : ((i < 6) ? 12'h260 : 12'h2FC);
    endfunction : flag_addr
    // Serial flags survive entry; the others are cleared when the core takes them
    function automatic logic [31:0] flag_after(input int i);
        return (i == 4 || i == 5) ? (32'h1 << POS[i]) : 32'h0;
    endfunction : flag_after
    task automatic wrap_up();
        $display("compares %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Every wait is bounded; running out ends the run as a failure
    task automatic step(inout int k);
        @(posedge clk);
        k++;
        if (k > 300)
        begin
            miscompares++;
            wrap_up();
        end
    endtask : step
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int k = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            step(k);
            if (awrdy)
                awvalid <= 1'b0;
            if (wrdy)
                wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        r = bresp;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        int k = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            step(k);
            if (arrdy)
                arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask : rd
    task automatic pulse(input int i);
        @(posedge clk);
        evt <= 9'h001 << i;
        @(posedge clk);
        evt <= 9'h000;
    endtask : pulse
    task automatic entry();
        int k = 0;
        while (ccnt === c)
            step(k);
        take <= 1'b0;
    endtask : entry
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            rd(RST_A[i]);
            chk(d, 32'h0);
            chk(r, 32'h0);
        end
        chk(ustart, 32'h00EC);
        chk(boot, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            wr(12'h268, seed);
            rd(12'h268);
            chk(d, seed & 32'h7);
        end
        wr(12'h268, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            pulse(i);
            rd(flag_addr(i));
            chk(d, 32'h1 << POS[i]);
            chk(req, 32'h0);
            wr(flag_addr(i), 32'h0);
            wr(12'h304, 32'h1FF);
        end
        wr(12'h2A0, 32'h9F);
        wr(12'h268, 32'h7);
        for (int i = 0; i < 9; i++)
        begin
            seed = lfsr(seed);
            gap  <= seed[3:0];
            take <= 1'b1;
            c = ccnt;
            pulse(i);
            entry();
            chk(cvec, VECS[i]);
            rd(flag_addr(i));
            chk(d, flag_after(i));
            wr(flag_addr(i), 32'h0);
        end
        wr(12'h2A0, 32'h1F);
        take <= 1'b1;
        pulse(0);
        repeat (3) @(posedge clk);
        chk(req, 32'h0);
        c = ccnt;
        wr(12'h2A0, 32'h9F);
        entry();
        chk(cvec, 32'h0003);
        wr(12'h2A0, 32'h0);
        // Both timers and ext b at once, then ext a
        @(posedge clk);
        evt <= 9'h00E;
        @(posedge clk);
        evt <= 9'h001;
        @(posedge clk);
        evt <= 9'h000;
        rd(12'h220);
        chk(d, 32'hAA);
        wr(12'h220, 32'h0);
        wr(12'h304, 32'h1FF);
        wr(12'h308, 32'h4);
        pulse(2);
        repeat (3) @(posedge clk);
        chk(line, 32'h1);
        wr(12'h304, 32'h4);
        repeat (2) @(posedge clk);
        chk(line, 32'h0);
        wr(12'h100, seed);
        chk(r, 32'h3);
        rd(12'h102);
        chk(r, 32'h3);
        chk(d, 32'h0);
        wrap_up();
    end
endmodule : tb
